/* File: verif/iface_cfg_monitor.sv */
// Port-level checker for the interface configuration register block
`timescale 1ns/1ps
module iface_cfg_monitor (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Register port
  input wire logic       reg_wr_strobe,
  input wire logic       reg_rd_strobe,
  input wire logic [7:0] reg_rdata,
  // Watched outputs and pins
  input wire logic       interface_clock_pin_oe,
  input wire logic       ep0_stall,
  input wire logic       usb_tx_valid,
  input wire logic       wake_input_pin,
  input wire logic       oscillator_off,
  input wire logic       pullup_disconnect,
  input wire logic [7:0] interrupt_mask,
  input wire logic       fourth_flag_or_select_oe
);
  logic [7:0] wr_hist;
  logic [7:0] rd_hist;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Recent strobe history
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_hist <= 8'h00;
      rd_hist <= 8'h00;
    end else begin
      wr_hist <= {wr_hist[6:0], reg_wr_strobe};
      rd_hist <= {rd_hist[6:0], reg_rd_strobe};
    end
  end

  property p_reset_vals;
    $fell(rst) |-> pullup_disconnect && !oscillator_off && interrupt_mask == 8'hff;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_stall_pulse;
    ep0_stall |=> !ep0_stall && (|wr_hist);
  endproperty
  a_stall_pulse: assert property (p_stall_pulse) else $error("stall not a pulse");
  property p_tx_pulse;
    usb_tx_valid |=> !usb_tx_valid;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("double fifo access");
  property p_clk_oe;
    $changed(interface_clock_pin_oe) |-> |wr_hist;
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock oe moved unasked");
  property p_pullup;
    $changed(pullup_disconnect) |-> |wr_hist;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up moved unasked");
  property p_standby;
    $rose(oscillator_off) |-> |wr_hist;
  endproperty
  a_standby: assert property (p_standby) else $error("standby without write");
  property p_wake;
    (!wake_input_pin) [*5] |-> !oscillator_off;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on pin");
  property p_flag_oe;
    $changed(fourth_flag_or_select_oe) |-> |wr_hist;
  endproperty
  a_flag_oe: assert property (p_flag_oe) else $error("shared pin moved unasked");
  property p_rdata_hold;
    !$stable(reg_rdata) |-> |rd_hist;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

bind interface_config_registers iface_cfg_monitor u_mon (
  .core_clk(core_clk), .rst(rst), .reg_wr_strobe(reg_wr_strobe),
  .reg_rd_strobe(reg_rd_strobe), .reg_rdata(reg_rdata),
  .interface_clock_pin_oe(interface_clock_pin_oe), .ep0_stall(ep0_stall),
  .usb_tx_valid(usb_tx_valid), .wake_input_pin(wake_input_pin),
  .oscillator_off(oscillator_off), .pullup_disconnect(pullup_disconnect),
  .interrupt_mask(interrupt_mask), .fourth_flag_or_select_oe(fourth_flag_or_select_oe)
);

/* File: verif/master_model.sv */
// External master model driving the command port and FIFO strobes
`timescale 1ns/1ps
module master_model (
  // Clock and read data
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  // Command port pins
  output logic      [7:0] reg_index,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr_strobe,
  output logic            reg_rd_strobe,
  // FIFO strobes, active low
  output logic            fifo_read_pin,
  output logic            fifo_write_pin,
  output logic      [7:0] fifo_data_in
);
  initial begin
    reg_index = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_strobe = 1'b0;
    reg_rd_strobe = 1'b0;
    fifo_read_pin = 1'b1;
    fifo_write_pin = 1'b1;
    fifo_data_in = 8'h00;
  end

  // One command access, index and data held around strobe
  task automatic access(input logic [7:0] idx, input logic [7:0] d, input logic wr,
                        output logic [7:0] q);
    @(negedge core_clk);
    reg_index = idx;
    reg_wdata = d;
    repeat (3) @(negedge core_clk);
    if (wr) reg_wr_strobe = 1'b1;
    else reg_rd_strobe = 1'b1;
    repeat (4) @(negedge core_clk);
    q = reg_rdata;
    reg_wr_strobe = 1'b0;
    reg_rd_strobe = 1'b0;
    reg_wdata = ~d; // Released bus shows no stale value
    repeat (3) @(negedge core_clk);
  endtask

  // Pointer then data gives the unindexed space
  task automatic ind_wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(8'h3a, a[7:0], 1'b1, q);
    access(8'h3b, a[15:8], 1'b1, q);
    access(8'h3c, d, 1'b1, q);
  endtask

  // Async strobe, three cycles each phase
  task automatic strobe_fifo(input logic rd, input logic [7:0] d);
    @(negedge core_clk);
    fifo_data_in = d;
    if (rd) fifo_read_pin = 1'b0;
    else fifo_write_pin = 1'b0;
    repeat (3) @(negedge core_clk);
    fifo_read_pin = 1'b1;
    fifo_write_pin = 1'b1;
    repeat (3) @(negedge core_clk);
    fifo_data_in = ~d;
  endtask
  // Standby only while unplugged; FIFO writes come only after the last reconfiguration
endmodule

/* File: verif/test_interface_config_registers.sv */
// Self-checking bench for the interface configuration register block
`timescale 1ns/1ps
module test_interface_config_registers;
  logic        core_clk, rst, link_clk, oe_pin, pend_pin, cs_n;
  logic [7:0]  reg_index, reg_wdata, reg_rdata, fifo_data_in, fifo_data_out;
  logic [7:0]  usb_rx_data, usb_tx_data, ep0_byte_count, interrupt_mask, q;
  logic        reg_wr_strobe, reg_rd_strobe, fifo_read_pin, fifo_write_pin;
  logic        clk_out, clk_oe, fifo_data_oe, empty_flag, full_flag, flag_out, flag_oe;
  logic        usb_rx_valid, usb_rx_ready, usb_tx_valid, usb_tx_packet_end;
  logic        setup_new, ep0_stall, usb_bus_activity, wake_n, oscillator_off, pullup_disc;
  logic [63:0] setup_packet;
  int          mismatches, compares, n, tx_cnt, stall_cnt;
  logic [7:0]  tx_last;

  // Core clock 10 ns, link clock 125 ns
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #62.5 link_clk = ~link_clk;
  end

  master_model u_master (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_wr_strobe(reg_wr_strobe), .reg_rd_strobe(reg_rd_strobe),
    .fifo_read_pin(fifo_read_pin), .fifo_write_pin(fifo_write_pin),
    .fifo_data_in(fifo_data_in));

  interface_config_registers u_dut (.core_clk(core_clk), .rst(rst), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_wr_strobe(reg_wr_strobe), .reg_rd_strobe(reg_rd_strobe),
    .reg_rdata(reg_rdata), .interface_clock_pin_in(link_clk),
    .interface_clock_pin_out(clk_out), .interface_clock_pin_oe(clk_oe),
    .fifo_read_pin(fifo_read_pin), .fifo_write_pin(fifo_write_pin),
    .fifo_output_enable_pin(oe_pin), .packet_end_pin(pend_pin),
    .fifo_data_in(fifo_data_in), .fifo_data_out(fifo_data_out),
    .fifo_data_oe(fifo_data_oe), .empty_flag(empty_flag), .full_flag(full_flag),
    .fourth_flag_or_select_in(cs_n), .fourth_flag_or_select_out(flag_out),
    .fourth_flag_or_select_oe(flag_oe), .usb_rx_data(usb_rx_data),
    .usb_rx_valid(usb_rx_valid), .usb_rx_ready(usb_rx_ready), .usb_tx_data(usb_tx_data),
    .usb_tx_valid(usb_tx_valid), .usb_tx_packet_end(usb_tx_packet_end),
    .setup_packet(setup_packet), .setup_new(setup_new), .ep0_stall(ep0_stall),
    .ep0_byte_count(ep0_byte_count), .usb_bus_activity(usb_bus_activity),
    .wake_input_pin(wake_n), .oscillator_off(oscillator_off),
    .pullup_disconnect(pullup_disc), .interrupt_mask(interrupt_mask));

  // Bytes and pulses handed to the USB side
  always @(posedge core_clk) begin
    if (usb_tx_valid === 1'b1) begin
      tx_cnt++;
      tx_last = usb_tx_data;
    end
    if (ep0_stall === 1'b1) stall_cnt++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic test_reset;
    u_master.access(8'h01, 8'h00, 1'b0, q);
    chk(q, 8'hc9);
    u_master.access(8'h2e, 8'h00, 1'b0, q);
    chk(q, 8'hff);
    chk({pullup_disc, oscillator_off, clk_oe, flag_oe}, 8'h08);
    $display("test_reset done");
  endtask

  task automatic test_config;
    u_master.access(8'h01, 8'h32, 1'b1, q);
    u_master.access(8'h01, 8'h00, 1'b0, q);
    chk(q, 8'h32);
    chk({pullup_disc, oscillator_off, clk_oe, flag_oe}, 8'h03);
    chk({7'h00, pullup_disc}, 8'h00);
    chk({7'h00, flag_oe}, 8'h01);
    u_master.access(8'h01, 8'hcd, 1'b1, q);
    chk({7'h00, oscillator_off}, 8'h01);
    @(negedge core_clk) wake_n = 1'b0;
    repeat (6) @(negedge core_clk);
    chk({7'h00, oscillator_off}, 8'h00);
    wake_n = 1'b1;
    u_master.access(8'h01, 8'hcd, 1'b1, q);
    @(negedge core_clk) usb_bus_activity = 1'b1;
    repeat (6) @(negedge core_clk);
    chk({7'h00, oscillator_off}, 8'h00);
    usb_bus_activity = 1'b0;
    u_master.access(8'h01, 8'hc9, 1'b1, q);
    $display("test_config done");
  endtask

  task automatic test_indirect;
    u_master.ind_wr(16'he609, 8'hc3);
    u_master.access(8'h3c, 8'h00, 1'b0, q);
    chk(q, 8'h03);
    u_master.ind_wr(16'he609, 8'h00);
    u_master.access(8'h3c, 8'h00, 1'b0, q);
    chk(q, 8'h00);
    u_master.access(8'h05, 8'h00, 1'b0, q);
    chk(q, 8'h00);
    $display("test_indirect done");
  endtask

  task automatic test_setup;
    @(negedge core_clk) setup_new = 1'b1;
    @(negedge core_clk) setup_new = 1'b0;
    for (int i = 0; i < 9; i++) begin
      u_master.access(8'h32, 8'h00, 1'b0, q);
      chk(q, setup_packet[8*(i%8) +: 8]);
    end
    u_master.access(8'h32, 8'h01, 1'b1, q);
    chk(8'(stall_cnt), 8'h01);
    $display("test_setup done");
  endtask

  task automatic test_fifo;
    n = 0;
    repeat (40) begin
      @(negedge core_clk);
      usb_rx_data = 8'(n);
      usb_rx_valid = 1'b1;
      if (usb_rx_ready === 1'b1) n++;
    end
    @(negedge core_clk) usb_rx_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(8'(n), 8'h20);
    chk({6'h00, full_flag, empty_flag}, 8'h01);
    oe_pin = 1'b0;
    for (int k = 0; k < 32; k++) begin
      chk(fifo_data_out, 8'(k));
      u_master.strobe_fifo(1'b1, 8'h00);
    end
    chk({7'h00, fifo_data_oe}, 8'h01);
    oe_pin = 1'b1;
    u_master.strobe_fifo(1'b1, 8'h00);
    chk({6'h00, full_flag, empty_flag}, 8'h02);
    u_master.strobe_fifo(1'b0, 8'h5a);
    u_master.strobe_fifo(1'b0, 8'ha5);
    chk(8'(tx_cnt), 8'h02);
    chk(tx_last, 8'ha5);
    $display("test_fifo done");
  endtask

  // Watchdog well past the roughly six hundred cycles needed
  initial begin
    #200us;
    mismatches++;
    stop_test();
  end

  initial begin
    mismatches = 0;
    compares = 0;
    tx_cnt = 0;
    stall_cnt = 0;
    rst = 1'b1;
    oe_pin = 1'b1;
    pend_pin = 1'b1;
    cs_n = 1'b0;
    usb_rx_data = 8'h00;
    usb_rx_valid = 1'b0;
    setup_new = 1'b0;
    setup_packet = 64'h8877665544332211;
    usb_bus_activity = 1'b0;
    wake_n = 1'b1;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    test_reset();
    test_config();
    test_indirect();
    test_setup();
    test_fifo();
    stop_test();
  end
endmodule

/* File: verilog/data_fifo.sv */
// Synchronous FIFO, valid/ready both sides, registered flags
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Flags from next count, so they stay registered
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data   = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at any depth
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

endmodule

/* File: verilog/iface_cfg_pkg.sv */
// Constants and carrier types for the interface configuration register block
package iface_cfg_pkg;

  // Register indices on the command port
  localparam logic [7:0] IDX_CONFIG     = 8'h01;
  localparam logic [7:0] IDX_INTMASK    = 8'h2e;
  localparam logic [7:0] IDX_DESCRIPTOR = 8'h30;
  localparam logic [7:0] IDX_EP_BUF     = 8'h31;
  localparam logic [7:0] IDX_SETUP      = 8'h32;
  localparam logic [7:0] IDX_EP_COUNT   = 8'h33;
  localparam logic [7:0] IDX_PTR_LO     = 8'h3a;
  localparam logic [7:0] IDX_PTR_HI     = 8'h3b;
  localparam logic [7:0] IDX_IND_DATA   = 8'h3c;

  // Polarity register address in extended space
  localparam logic [15:0] XADDR_POLARITY = 16'he609;

  // Reset values and writable masks
  localparam logic [7:0] CONFIG_RESET   = 8'hc9;
  localparam logic [7:0] INTMASK_RESET  = 8'hff;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [7:0] POLARITY_MASK  = 8'h3f;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // Setup packet length in bytes
  localparam int SETUP_BYTES = 8;

  // Phase accumulator for the internal clock
  localparam int CORE_CLK_KHZ   = 100000;
  localparam int INT_CLK_30_KHZ = 30000;
  localparam int INT_CLK_48_KHZ = 48000;
  localparam int ACC_BITS       = 16;
  localparam logic [ACC_BITS-1:0] INC_30 =
    ACC_BITS'((INT_CLK_30_KHZ * 64'd65536) / CORE_CLK_KHZ);
  localparam logic [ACC_BITS-1:0] INC_48 =
    ACC_BITS'((INT_CLK_48_KHZ * 64'd65536) / CORE_CLK_KHZ);

  // Data buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;

  // Interface configuration fields, bit 7 first
  typedef struct packed {
    logic clk_src_internal;
    logic freq_48;
    logic clk_oe;
    logic clk_invert;
    logic async_mode;
    logic standby;
    logic flag_pin_is_output;
    logic pullup_disconnect;
  } cfg_s;

  // Pin polarity fields, bit 7 first; 1 means active high
  typedef struct packed {
    logic [1:0] unused;
    logic       packet_end;
    logic       output_enable;
    logic       read;
    logic       write;
    logic       empty;
    logic       full;
  } polarity_s;

endpackage

/* File: verilog/interface_config_registers.sv */
// Interface configuration registers with FIFO pin control for the master port
//
// Behaviour
// RULE1: Clock source 0 is the external pin, 1 (reset) internal.
// RULE2: Internal clock 30 MHz at frequency bit 0, 48 MHz at 1.
// RULE3: Clock pin floats at output enable 0, driven at 1.
// RULE4: Invert 0 uses the rising edge; 1 inverts the clock.
// RULE5: Sync mode samples read/write enables on interface clock edges.
// RULE6: Async mode (reset) needs no clock; controls are strobes.
// RULE7: Writing 1 to standby turns the oscillator off.
// RULE8: Master sets standby after suspend interrupt, or if disconnected.
// RULE9: Standby ends on USB bus activity or the wake input.
// RULE10: Pin function 0 makes shared pin a select input, 1 a flag.
// RULE11: Disconnect bit 1 floats the D+ pull-up; 0 pulls it high.
// RULE12: Configuration at 01, all read/write, reset bits 7,6,3,0 set.
// RULE13: Indices 3A, 3B, 3C: pointer low, pointer high, data.
// RULE14: Index 32 reads eight setup bytes; a write stalls the control endpoint.
// RULE15: Master waits 35 us after ready before FIFO writes post length change.
// RULE16: Master waits 85 us after ready before FIFO writes post flush write.
// RULE17: Polarity holds six pin polarities, top two read-only, reset zero.
// RULE18: Async strobes synchronised, each gives exactly one access.
`timescale 1ns/1ps
module interface_config_registers #(
  parameter int FIFO_WIDTH = iface_cfg_pkg::FIFO_WIDTH,
  parameter int FIFO_DEPTH = iface_cfg_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Command register port
  input  wire logic [7:0]            reg_index,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr_strobe,
  input  wire logic                  reg_rd_strobe,
  output logic      [7:0]            reg_rdata,
  // Interface clock pin
  input  wire logic                  interface_clock_pin_in,
  output logic                       interface_clock_pin_out,
  output logic                       interface_clock_pin_oe,
  // FIFO pins
  input  wire logic                  fifo_read_pin,
  input  wire logic                  fifo_write_pin,
  input  wire logic                  fifo_output_enable_pin,
  input  wire logic                  packet_end_pin,
  input  wire logic [FIFO_WIDTH-1:0] fifo_data_in,
  output logic      [FIFO_WIDTH-1:0] fifo_data_out,
  output logic                       fifo_data_oe,
  output logic                       empty_flag,
  output logic                       full_flag,
  // Shared fourth flag or chip select pin
  input  wire logic                  fourth_flag_or_select_in,
  output logic                       fourth_flag_or_select_out,
  output logic                       fourth_flag_or_select_oe,
  // USB engine, receive data to master
  input  wire logic [FIFO_WIDTH-1:0] usb_rx_data,
  input  wire logic                  usb_rx_valid,
  output logic                       usb_rx_ready,
  // USB engine, master write data
  output logic      [FIFO_WIDTH-1:0] usb_tx_data,
  output logic                       usb_tx_valid,
  output logic                       usb_tx_packet_end,
  // Control endpoint
  input  wire logic [63:0]           setup_packet,
  input  wire logic                  setup_new,
  output logic                       ep0_stall,
  output logic      [7:0]            ep0_byte_count,
  // Power and connection
  input  wire logic                  usb_bus_activity,
  input  wire logic                  wake_input_pin,
  output logic                       oscillator_off,
  output logic                       pullup_disconnect,
  output logic      [7:0]            interrupt_mask
);

  // Pin synchroniser lanes
  localparam int NS = 34;

  iface_cfg_pkg::cfg_s      cfg;
  iface_cfg_pkg::polarity_s pol;
  logic [7:0]  ptr_lo;
  logic [7:0]  ptr_hi;
  logic [2:0]  setup_sel;
  logic [iface_cfg_pkg::ACC_BITS-1:0] phase;
  logic        sel_clk_prev;
  logic        rd_act_prev;
  logic        wr_act_prev;
  logic        pe_act_prev;
  logic [NS-1:0] s_level;
  logic [NS-1:0] s_rise;

  // All pin inputs pass two flip-flops first
  pin_sync #(
    .W (NS)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({reg_index, reg_wdata, fifo_data_in, reg_wr_strobe, reg_rd_strobe,
                fifo_read_pin, fifo_write_pin, fifo_output_enable_pin, packet_end_pin,
                fourth_flag_or_select_in, interface_clock_pin_in, usb_bus_activity,
                wake_input_pin}),
    .level    (s_level),
    .rise     (s_rise)
  );

  // Synchronised pin names
  wire [7:0] idx_s      = s_level[33:26];
  wire [7:0] wdata_s    = s_level[25:18];
  wire [7:0] fdata_s    = s_level[17:10];
  wire       reg_wr_evt = s_rise[9];
  wire       reg_rd_evt = s_rise[8];
  wire       rd_pin_s   = s_level[7];
  wire       wr_pin_s   = s_level[6];
  wire       oe_pin_s   = s_level[5];
  wire       pe_pin_s   = s_level[4];
  wire       cs_pin_s   = s_level[3];
  wire       interface_clock_pin_s    = s_level[2];
  wire       activity_s = s_level[1];
  wire       wake_s     = s_level[0];

  // Command decode
  wire wr_config   = reg_wr_evt & (idx_s == iface_cfg_pkg::IDX_CONFIG);
  wire wr_intmask  = reg_wr_evt & (idx_s == iface_cfg_pkg::IDX_INTMASK);
  wire wr_setup    = reg_wr_evt & (idx_s == iface_cfg_pkg::IDX_SETUP);
  wire wr_epcount  = reg_wr_evt & (idx_s == iface_cfg_pkg::IDX_EP_COUNT);
  wire wr_ptr_lo   = reg_wr_evt & (idx_s == iface_cfg_pkg::IDX_PTR_LO);
  wire wr_ptr_hi   = reg_wr_evt & (idx_s == iface_cfg_pkg::IDX_PTR_HI);
  wire wr_ind      = reg_wr_evt & (idx_s == iface_cfg_pkg::IDX_IND_DATA);
  wire rd_setup    = reg_rd_evt & (idx_s == iface_cfg_pkg::IDX_SETUP);
  wire ptr_is_pol  = {ptr_hi, ptr_lo} == iface_cfg_pkg::XADDR_POLARITY;

  // Upper polarity pair reads zero
  wire [7:0] pol_image = pol & iface_cfg_pkg::POLARITY_MASK; // RULE17

  // Setup byte picked by the read cursor, byte 0 first
  wire [7:0] setup_byte = setup_packet[{setup_sel, 3'b000} +: 8]; // RULE14

  // Read selection; unmapped and write-only indices read zero
  wire [7:0] rd_value =
    (idx_s == iface_cfg_pkg::IDX_CONFIG)   ? cfg :
    (idx_s == iface_cfg_pkg::IDX_INTMASK)  ? interrupt_mask :
    (idx_s == iface_cfg_pkg::IDX_SETUP)    ? setup_byte :
    (idx_s == iface_cfg_pkg::IDX_EP_COUNT) ? ep0_byte_count :
    (idx_s == iface_cfg_pkg::IDX_PTR_LO)   ? ptr_lo :
    (idx_s == iface_cfg_pkg::IDX_PTR_HI)   ? ptr_hi :
    (idx_s == iface_cfg_pkg::IDX_IND_DATA) ? (ptr_is_pol ? pol_image
                                                          : iface_cfg_pkg::ZERO_BYTE) :
    iface_cfg_pkg::ZERO_BYTE;

  // Wake pin active low, bus activity high
  wire wake_req = ~wake_s | activity_s;

  // Config register; a same-cycle wake beats a standby write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg <= iface_cfg_pkg::CONFIG_RESET; // RULE12
    end else if (wr_config) begin
      cfg         <= wdata_s; // RULE12
      cfg.standby <= wdata_s[2] & ~wake_req; // RULE7
    end else if (cfg.standby & wake_req) begin
      cfg.standby <= 1'b0; // RULE9
    end
  end

  // Oscillator and pull-up follow their bits
  assign oscillator_off    = cfg.standby; // RULE7
  assign pullup_disconnect = cfg.pullup_disconnect; // RULE11

  // Other indexed registers and pointer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interrupt_mask <= iface_cfg_pkg::INTMASK_RESET;
      ep0_byte_count <= iface_cfg_pkg::ZERO_BYTE;
      ptr_lo         <= iface_cfg_pkg::ZERO_BYTE;
      ptr_hi         <= iface_cfg_pkg::ZERO_BYTE;
    end else begin
      if (wr_intmask) interrupt_mask <= wdata_s;
      if (wr_epcount) ep0_byte_count <= wdata_s;
      if (wr_ptr_lo) ptr_lo <= wdata_s; // RULE13
      if (wr_ptr_hi) ptr_hi <= wdata_s; // RULE13
    end
  end

  // Indirect write reaches polarity register on pointer match
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pol <= iface_cfg_pkg::POLARITY_RESET; // RULE17
    end else if (wr_ind & ptr_is_pol) begin
      pol <= wdata_s & iface_cfg_pkg::POLARITY_MASK; // RULE13
    end
  end

  // Read data captured once per strobe, then held
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= iface_cfg_pkg::ZERO_BYTE;
    end else if (reg_rd_evt) begin
      reg_rdata <= rd_value; // RULE13
    end
  end

  // Setup cursor restarts per packet, wraps after eight
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      setup_sel <= 3'h0;
      ep0_stall <= 1'b0;
    end else begin
      if (setup_new) begin
        setup_sel <= 3'h0;
      end else if (rd_setup) begin
        setup_sel <= 3'(setup_sel + 3'h1); // RULE14
      end
      ep0_stall <= wr_setup; // RULE14
    end
  end

  // Phase accumulator clock; one-cycle edge jitter buys freedom from a PLL
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
    end else begin
      phase <= phase + (cfg.freq_48 ? iface_cfg_pkg::INC_48
                                    : iface_cfg_pkg::INC_30); // RULE2
    end
  end

  // Source and polarity select, then edge detect
  wire int_clk  = phase[iface_cfg_pkg::ACC_BITS-1];
  wire src_clk  = cfg.clk_src_internal ? int_clk : interface_clock_pin_s; // RULE1
  wire sel_clk  = src_clk ^ cfg.clk_invert; // RULE4
  wire if_edge  = sel_clk & ~sel_clk_prev; // RULE4

  // Clock pin drive; only the internal clock is ever sent out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interface_clock_pin_out <= 1'b0;
      interface_clock_pin_oe  <= 1'b0;
    end else begin
      interface_clock_pin_out <= int_clk ^ cfg.clk_invert;
      interface_clock_pin_oe  <= cfg.clk_oe; // RULE3
    end
  end

  // Pins to active-true via polarity bits
  wire rd_act   = rd_pin_s ^ ~pol.read;
  wire wr_act   = wr_pin_s ^ ~pol.write;
  wire oe_act   = oe_pin_s ^ ~pol.output_enable;
  wire pe_act   = pe_pin_s ^ ~pol.packet_end;
  // Active-low select counts only while the pin is an input
  wire selected = cfg.flag_pin_is_output | ~cs_pin_s; // RULE10

  // Async: once per strobe; sync: per enabled clock edge
  wire rd_access = selected & (cfg.async_mode ? (rd_act & ~rd_act_prev) // RULE6 RULE18
                                              : (if_edge & rd_act)); // RULE5
  wire wr_access = selected & (cfg.async_mode ? (wr_act & ~wr_act_prev) // RULE6 RULE18
                                              : (if_edge & wr_act)); // RULE5
  wire pe_access = selected & (cfg.async_mode ? (pe_act & ~pe_act_prev)
                                              : (if_edge & pe_act));

  // Strobe history starts active: no false edge while the sync fills
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_clk_prev <= 1'b0;
      rd_act_prev  <= 1'b1;
      wr_act_prev  <= 1'b1;
      pe_act_prev  <= 1'b1;
    end else begin
      sel_clk_prev <= sel_clk;
      rd_act_prev  <= rd_act;
      wr_act_prev  <= wr_act;
      pe_act_prev  <= pe_act;
    end
  end

  // Receive buffer, USB engine to master
  logic [FIFO_WIDTH-1:0] head_data;
  logic                  head_valid;

  data_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (usb_rx_data),
    .in_valid  (usb_rx_valid),
    .in_ready  (usb_rx_ready),
    .out_data  (head_data),
    .out_valid (head_valid),
    .out_ready (rd_access)
  );

  // Master-side data and flags; empty reads dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fifo_data_out             <= '0;
      fifo_data_oe              <= 1'b0;
      empty_flag                <= 1'b0;
      full_flag                 <= 1'b0;
      fourth_flag_or_select_out <= 1'b0;
      fourth_flag_or_select_oe  <= 1'b0;
    end else begin
      fifo_data_out             <= head_data;
      fifo_data_oe              <= oe_act & selected;
      empty_flag                <= pol.empty ? ~head_valid : head_valid;
      full_flag                 <= pol.full ? ~usb_rx_ready : usb_rx_ready;
      fourth_flag_or_select_out <= pol.empty ? ~head_valid : head_valid; // RULE10
      fourth_flag_or_select_oe  <= cfg.flag_pin_is_output; // RULE10
    end
  end

  // Master writes go out as one-cycle pulses
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      usb_tx_data       <= '0;
      usb_tx_valid      <= 1'b0;
      usb_tx_packet_end <= 1'b0;
    end else begin
      if (wr_access) usb_tx_data <= fdata_s;
      usb_tx_valid      <= wr_access; // RULE5
      usb_tx_packet_end <= pe_access;
    end
  end

endmodule

/* File: verilog/pin_sync.sv */
// Two-stage pin synchroniser with edge detect
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Asynchronous inputs
  input  wire logic [W-1:0] async_in,
  // Synchronised level and edges
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // Only stage two reads stage one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;

endmodule
